// *** src/qwrb_map.svh ***
/*
 * Constants for the quad wiper register bank: bus address fields,
 * instruction opcodes, bit counts of a byte frame, wiper limits.
 * Assumes it is included by its bare name by the package and the bench.
 */
// ****************************************************************
// Functional notes
// ****************************************************************
// Functional notes
// - Four separate 8-bit wiper registers, one per pot
// - Exactly one of 256 taps selected per pot
// - Four 8-bit saved settings per pot, sixteen
// - Power-up copies first saved setting into wiper
// - Write-protect low blocks nonvolatile writes, wipers writable
// - Write-protect high allows all reads and writes
// - Respond only when address matches strap inputs
// - Serial data driven open-drain only
// - All transfers clocked by master's serial clock
// - Master reads and writes every wiper and setting
// - Commands move data between wiper and settings
// - Increment/decrement mode steps the wiper setting
`ifndef QWRB_MAP_SVH
`define QWRB_MAP_SVH

// ****************************************************************
// Bus address byte
// ****************************************************************
`define QWRB_DEV_TYPE 4'h5
`define QWRB_TYPE_MSB 7
`define QWRB_TYPE_LSB 4
`define QWRB_STRAP_MSB 3
`define QWRB_STRAP_LSB 0

// ****************************************************************
// Instruction opcodes (high nibble of instruction byte)
// ****************************************************************
`define QWRB_OP_RD_WIPER 4'h9
`define QWRB_OP_WR_WIPER 4'hA
`define QWRB_OP_RD_SAVED 4'hB
`define QWRB_OP_WR_SAVED 4'hC
`define QWRB_OP_LD_WIPER 4'hD
`define QWRB_OP_ST_SAVED 4'hE
`define QWRB_OP_STEP 4'h2

// ****************************************************************
// Frame bit counts and sizes
// ****************************************************************
`define QWRB_BIT_LAST 4'd7
`define QWRB_BIT_ACK 4'd8
`define QWRB_BIT_END 4'd9
`define QWRB_POTS 4
`define QWRB_SLOTS 16
`define QWRB_WIPER_MAX 8'hFF
`define QWRB_WIPER_MIN 8'h00
`define QWRB_WIPER_RST 8'h00
`define QWRB_SAVED_BLANK 8'h00

`endif

// *** src/qwrb_pkg.sv ***
/*
 * Types of the quad wiper register bank: states, instruction layout,
 * wiper and tap arrays.
 * Assumes qwrb_map.svh is on the include path.
 */
package qwrb_pkg;
   `include "qwrb_map.svh"

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [7:0] {
      ST_RECALL = 8'b0000_0001,
      ST_IDLE = 8'b0000_0010,
      ST_ADDR = 8'b0000_0100,
      ST_INSTR = 8'b0000_1000,
      ST_WDATA = 8'b0001_0000,
      ST_STEP = 8'b0010_0000,
      ST_RDATA = 8'b0100_0000,
      ST_HOLD = 8'b1000_0000
   } qwrb_state_t;

   typedef struct packed {
      logic [3:0] op;
      logic [1:0] pot;
      logic [1:0] slot;
   } qwrb_instr_t;

   typedef logic [3:0][7:0] qwrb_wiper_arr_t;
   typedef logic [3:0][255:0] qwrb_tap_arr_t;
   typedef logic [15:0][7:0] qwrb_saved_arr_t;
endpackage

// *** src/qwrb_sync.sv ***
/*
 * Two-flop synchroniser for pin levels entering the system clock.
 * Assumes inputs are asynchronous levels; reset value is a parameter.
 */
`timescale 1ns/10ps
module qwrb_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   // ****************************************************************
   // Two stages; first stage read only by second
   // ****************************************************************
   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end
endmodule

// *** src/qwrb_core.sv ***
/*
 * Quad wiper register bank: serial bus slave, four wiper registers,
 * sixteen saved settings, recall after reset, write protect, tap decode.
 * Assumes an external open-drain wire for serial data, a master that
 * clocks serial_clk, and pins that are asynchronous to clk_sys.
 */
`timescale 1ns/10ps
module qwrb_core (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic serial_clk,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic wp_b,
   input wire logic address_strap_0,
   input wire logic address_strap_1,
   input wire logic address_strap_2,
   input wire logic address_strap_3,
   output qwrb_pkg::qwrb_wiper_arr_t wiper_tap_select,
   output qwrb_pkg::qwrb_tap_arr_t tap_onehot
);
   import qwrb_pkg::*;

   localparam logic [255:0] TAP_ONE = 256'h1;

   logic [7:0] rx_shift;
   logic [7:0] next_rx_shift;
   logic [6:0] pins_s;
   logic scl_s, sda_s, wp_s;
   logic [3:0] straps_s;
   logic scl_d, sda_d, next_scl_d, next_sda_d;
   logic rise_s, fall_s, start_s, stop_s, rx_state, byte_done;
   qwrb_state_t state, next_state, after, next_after;
   logic [3:0] bitcnt, next_bitcnt;
   qwrb_instr_t instr, next_instr, rx_instr;
   logic [7:0] tx, next_tx;
   logic ack_q, next_ack, mack_q, next_mack, sda_oe_q, next_oe;
   qwrb_wiper_arr_t wiper, next_wiper;
   // Blank at first power-up so the first recall loads a known tap
   qwrb_saved_arr_t saved = {`QWRB_SLOTS{`QWRB_SAVED_BLANK}};
   qwrb_saved_arr_t next_saved;
   qwrb_tap_arr_t tap_q, next_tap;

   // Flat index of a saved setting: pot then slot
   function automatic logic [3:0] slot_idx(input qwrb_instr_t i);
      return {i.pot, i.slot};
   endfunction

   // ****************************************************************
   // Link domain: serial data shifted on the master's clock
   // ****************************************************************
   // Data bits are caught on the master's rising edge
   always_comb begin
      next_rx_shift = {rx_shift[6:0], sda_i};
   end

   // No reset here: the master's clock stops outside frames
   always_ff @(posedge serial_clk) begin
      rx_shift <= next_rx_shift;
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   qwrb_sync #(
      .WIDTH(7),
      .RST_VAL(7'h7F)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .d({serial_clk, sda_i, wp_b, address_strap_3, address_strap_2, address_strap_1, address_strap_0}),
      .q(pins_s)
   );

   // Pin history for edge and start/stop detection
   always_comb begin
      {scl_s, sda_s, wp_s, straps_s} = pins_s;
      next_scl_d = scl_s;
      next_sda_d = sda_s;
      rise_s = scl_s && !scl_d;
      fall_s = !scl_s && scl_d;
      start_s = scl_s && scl_d && sda_d && !sda_s;
      stop_s = scl_s && scl_d && !sda_d && sda_s;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= next_scl_d;
         sda_d <= next_sda_d;
      end
   end

   // ****************************************************************
   // Protocol engine and register bank
   // ****************************************************************
   // The shift register settles at the real edge, well before the
   // synchronised edge is seen, so it is read here as a stable word.
   always_comb begin
      rx_instr = qwrb_instr_t'(rx_shift);
      rx_state = state inside {ST_ADDR, ST_INSTR, ST_WDATA, ST_STEP};
      byte_done = rise_s && rx_state && (bitcnt == `QWRB_BIT_LAST);
      next_state = state;
      next_after = after;
      next_bitcnt = bitcnt;
      next_instr = instr;
      next_tx = tx;
      next_ack = ack_q;
      next_mack = mack_q;
      next_oe = sda_oe_q;
      next_wiper = wiper;
      next_saved = saved;
      if (state == ST_RECALL) begin
         for (int p = 0; p < `QWRB_POTS; p++) begin
            next_wiper[p] = saved[4 * p];
         end
         next_state = ST_IDLE;
      end else if (start_s) begin
         next_state = ST_ADDR;
         next_bitcnt = 4'd0;
         next_oe = 1'b0;
      end else if (stop_s) begin
         next_state = ST_IDLE;
         next_oe = 1'b0;
      end else if (rise_s && state != ST_IDLE && state != ST_HOLD) begin
         next_bitcnt = 4'(bitcnt + 4'd1);
         if (state == ST_RDATA && bitcnt == `QWRB_BIT_ACK) begin
            next_mack = !sda_s;
         end
         if (byte_done) begin
            unique case (state)
               ST_ADDR: begin
                  // Strap match gates every later answer
                  next_ack = (rx_shift[`QWRB_TYPE_MSB:`QWRB_TYPE_LSB] == `QWRB_DEV_TYPE) &&
                     (rx_shift[`QWRB_STRAP_MSB:`QWRB_STRAP_LSB] == straps_s);
                  next_after = next_ack ? ST_INSTR : ST_IDLE;
               end
               ST_INSTR: begin
                  next_instr = rx_instr;
                  next_ack = 1'b1;
                  next_after = ST_HOLD;
                  case (rx_instr.op)
                     `QWRB_OP_RD_WIPER: begin
                        next_tx = wiper[rx_instr.pot];
                        next_after = ST_RDATA;
                     end
                     `QWRB_OP_RD_SAVED: begin
                        next_tx = saved[slot_idx(rx_instr)];
                        next_after = ST_RDATA;
                     end
                     `QWRB_OP_WR_WIPER, `QWRB_OP_WR_SAVED: begin
                        next_after = ST_WDATA;
                     end
                     `QWRB_OP_STEP: begin
                        next_after = ST_STEP;
                     end
                     `QWRB_OP_LD_WIPER: begin
                        next_wiper[rx_instr.pot] = saved[slot_idx(rx_instr)];
                     end
                     `QWRB_OP_ST_SAVED: begin
                        // A refused store answers with no acknowledge
                        if (wp_s) begin
                           next_saved[slot_idx(rx_instr)] = wiper[rx_instr.pot];
                        end else begin
                           next_ack = 1'b0;
                        end
                     end
                     default: begin
                        next_ack = 1'b0;
                     end
                  endcase
               end
               ST_WDATA: begin
                  next_after = ST_WDATA;
                  next_ack = 1'b1;
                  if (instr.op == `QWRB_OP_WR_WIPER) begin
                     next_wiper[instr.pot] = rx_shift;
                  end else if (wp_s) begin
                     next_saved[slot_idx(instr)] = rx_shift;
                  end else begin
                     next_ack = 1'b0;
                  end
               end
               ST_STEP: begin
                  // Bit 0 set steps up, clear steps down; ends saturate
                  next_after = ST_STEP;
                  next_ack = 1'b1;
                  if (rx_shift[0] && wiper[instr.pot] != `QWRB_WIPER_MAX) begin
                     next_wiper[instr.pot] = wiper[instr.pot] + 8'h01;
                  end else if (!rx_shift[0] && wiper[instr.pot] != `QWRB_WIPER_MIN) begin
                     next_wiper[instr.pot] = wiper[instr.pot] - 8'h01;
                  end
               end
               ST_RECALL, ST_IDLE, ST_RDATA, ST_HOLD: begin
               end
            endcase
         end
      end else if (fall_s && state != ST_IDLE && state != ST_HOLD) begin
         // Data changes only while the serial clock is low
         if (bitcnt == `QWRB_BIT_ACK) begin
            next_oe = rx_state && ack_q;
         end else if (bitcnt == `QWRB_BIT_END) begin
            next_bitcnt = 4'd0;
            if (state == ST_RDATA) begin
               next_state = mack_q ? ST_RDATA : ST_HOLD;
            end else begin
               next_state = after;
            end
            next_oe = (next_state == ST_RDATA) && !tx[7];
         end else if (state == ST_RDATA && bitcnt != 4'd0) begin
            next_oe = (bitcnt < `QWRB_BIT_ACK) && !tx[3'd7 - bitcnt[2:0]];
         end
      end
   end

   // Saved settings keep their contents through reset
   always_ff @(posedge clk_sys) begin
      saved <= next_saved;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= ST_RECALL;
         after <= ST_IDLE;
         bitcnt <= 4'd0;
         instr <= '0;
         tx <= 8'h00;
         ack_q <= 1'b0;
         mack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         wiper <= {`QWRB_POTS{`QWRB_WIPER_RST}};
      end else begin
         state <= next_state;
         after <= next_after;
         bitcnt <= next_bitcnt;
         instr <= next_instr;
         tx <= next_tx;
         ack_q <= next_ack;
         mack_q <= next_mack;
         sda_oe_q <= next_oe;
         wiper <= next_wiper;
      end
   end

   // ****************************************************************
   // Tap decode and outputs
   // ****************************************************************
   // One switch per pot closed, chosen by its wiper alone
   for (genvar g = 0; g < `QWRB_POTS; g++) begin : g_tap
      always_comb begin
         next_tap[g] = TAP_ONE << wiper[g];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tap_q <= {`QWRB_POTS{TAP_ONE}};
      end else begin
         tap_q <= next_tap;
      end
   end

   // Open drain: the pad only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = sda_oe_q;
   assign wiper_tap_select = wiper;
   assign tap_onehot = tap_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_WIPER_WRITE: assert property (
      byte_done && state == ST_WDATA && instr.op == `QWRB_OP_WR_WIPER
      |=> wiper[$past(instr.pot)] == $past(rx_shift))
      else $error("wiper write not taken");

   AST_TAP_ONEHOT: assert property (
      1'b1 |=> tap_onehot[0] == (TAP_ONE << $past(wiper[0])) && $onehot(tap_onehot[3]))
      else $error("tap select not one-hot of wiper");

   AST_RECALL: assert property (
      state == ST_RECALL |=> wiper[0] == $past(saved[0]) && wiper[1] == $past(saved[4]) &&
      wiper[2] == $past(saved[8]) && wiper[3] == $past(saved[12]) && state == ST_IDLE)
      else $error("power-up recall wrong");

   AST_WP_BLOCK: assert property (
      !wp_s |=> saved == $past(saved))
      else $error("saved setting changed under write protect");

   AST_WP_ALLOW: assert property (
      byte_done && state == ST_WDATA && instr.op == `QWRB_OP_WR_SAVED && wp_s
      |=> saved[$past(slot_idx(instr))] == $past(rx_shift) && ack_q)
      else $error("saved setting write lost");

   AST_ADDR_MISS: assert property (
      byte_done && state == ST_ADDR && rx_shift[3:0] != straps_s
      |=> !ack_q && after == ST_IDLE)
      else $error("answered a foreign address");

   AST_SDA_ON_FALL: assert property (
      $changed(sda_oe) |-> $past(fall_s || start_s || stop_s) && sda_o == 1'b0)
      else $error("data line moved outside clock low");

   AST_LOAD: assert property (
      byte_done && state == ST_INSTR && rx_instr.op == `QWRB_OP_LD_WIPER
      |=> wiper[$past(rx_instr.pot)] == $past(saved[slot_idx(rx_instr)]))
      else $error("saved-to-wiper move wrong");

   AST_STEP_UP: assert property (
      byte_done && state == ST_STEP && rx_shift[0] && wiper[instr.pot] != `QWRB_WIPER_MAX
      |=> wiper[$past(instr.pot)] == 8'($past(wiper[instr.pot]) + 8'h01))
      else $error("increment step wrong");

   AST_STORE_BLOCK: assert property (
      byte_done && state == ST_INSTR && rx_instr.op == `QWRB_OP_ST_SAVED && !wp_s
      |=> !ack_q ##1 saved == $past(saved, 2))
      else $error("wiper store not refused");
endmodule

// *** bench/qwrb_master.sv ***
/*
 * Bus master model for the quad wiper register bank: start, stop,
 * byte write with ack sampling, byte read with ack or nack.
 * Assumes sda_line is the resolved open-drain wire with a pull-up.
 */
`timescale 1ns/10ps
module qwrb_master (
   output logic serial_clk,
   output logic sda_m,
   input wire logic sda_line
);
   // ****************************************************************
   // Bit timing
   // ****************************************************************
   // Quarter of the 125 ns link period; stall stretches the low phase
   real q = 31.25;
   real stall = 0.0;

   // Clock stands high and data is released between frames
   initial begin
      serial_clk = 1'b1;
      sda_m = 1'b1;
   end

   // One clock pulse; data only changes while the clock is low
   task automatic pulse(output logic smp);
      #(q + stall);
      serial_clk = 1'b1;
      #(q);
      smp = sda_line;
      #(q);
      serial_clk = 1'b0;
      #(q);
   endtask

   task automatic start();
      sda_m = 1'b1;
      serial_clk = 1'b1;
      #(q);
      sda_m = 1'b0;
      #(q);
      serial_clk = 1'b0;
      #(q);
   endtask

   task automatic stop();
      sda_m = 1'b0;
      #(q);
      serial_clk = 1'b1;
      #(q);
      sda_m = 1'b1;
      #(q);
   endtask

   // Most significant bit first, then release for the device's ack
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic smp;
      for (int i = 7; i >= 0; i--) begin
         sda_m = d[i];
         pulse(smp);
      end
      sda_m = 1'b1;
      pulse(smp);
      ack = ~smp;
   endtask

   // Line released while the device drives; then our ack or nack
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic smp;
      sda_m = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         pulse(smp);
         d[i] = smp;
      end
      // Ack level stands until the next byte or the stop changes it
      sda_m = ~ack;
      pulse(smp);
   endtask
endmodule

// *** bench/tb.sv ***
/*
 * Self-checking bench of the quad wiper register bank: register
 * writes and reads, recall at reset, moves, steps, protection, address.
 * Assumes qwrb_master as the far side and qwrb_map.svh on the path.
 */
`timescale 1ns/10ps
module tb;
   import qwrb_pkg::*;
   `include "qwrb_map.svh"

   logic clk_sys, rst_b, wp_b, serial_clk, sda_m, sda_line, sda_o, sda_oe;
   logic [3:0] strap;
   qwrb_wiper_arr_t wiper;
   qwrb_tap_arr_t taps;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   int wip[4];
   int sav[16];

   // ****************************************************************
   // Clock, wire, instances
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Pull-up wire: low when either party pulls it
   assign sda_line = (sda_oe ? sda_o : 1'b1) & sda_m;

   qwrb_master i_qwrb_master (.serial_clk(serial_clk), .sda_m(sda_m), .sda_line(sda_line));

   qwrb_core i_qwrb_core (
      .clk_sys(clk_sys), .rst_b(rst_b), .serial_clk(serial_clk), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe(sda_oe), .wp_b(wp_b), .address_strap_0(strap[0]),
      .address_strap_1(strap[1]), .address_strap_2(strap[2]), .address_strap_3(strap[3]),
      .wiper_tap_select(wiper), .tap_onehot(taps));

   // ****************************************************************
   // Checking and reporting
   // ****************************************************************
   task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Hang guard, far above the roughly 63k cycles of traffic
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 90000) begin
         error_cnt++;
         $display("CHECK FAILED timeout expected done seen hang");
         end_sim();
      end
   end

   // Data only ever pulls low
   always @(posedge clk_sys) begin
      if (sda_oe === 1'b1) chk("sda_o", 0, sda_o);
   end

   // Wipers and their one-hot taps against the model
   task automatic cmp_all();
      logic [255:0] e;
      for (int p = 0; p < 4; p++) begin
         e = '0;
         e[wip[p]] = 1'b1;
         chk("wiper", wip[p], wiper[p]);
         chk("tap", e, taps[p]);
      end
   endtask

   // ****************************************************************
   // Bus transactions
   // ****************************************************************
   task automatic send(input logic [3:0] adr, input logic [7:0] ins, input logic [7:0] d, output logic [2:0] ak);
      logic a;
      i_qwrb_master.start();
      i_qwrb_master.wr_byte({`QWRB_DEV_TYPE, adr}, a);
      ak[2] = a;
      i_qwrb_master.wr_byte(ins, a);
      ak[1] = a;
      i_qwrb_master.wr_byte(d, a);
      ak[0] = a;
      i_qwrb_master.stop();
      repeat (4) @(posedge clk_sys);
   endtask

   // Move and store carry no data byte
   task automatic move(input logic [7:0] ins, input logic exp_ack);
      logic a;
      i_qwrb_master.start();
      i_qwrb_master.wr_byte({`QWRB_DEV_TYPE, strap}, a);
      i_qwrb_master.wr_byte(ins, a);
      i_qwrb_master.stop();
      repeat (4) @(posedge clk_sys);
      chk("move ack", exp_ack, a);
   endtask

   // Master acks the first byte, so the device repeats it once
   task automatic rd(input logic [7:0] ins, input int e);
      logic a;
      logic [7:0] d;
      logic [7:0] d2;
      i_qwrb_master.start();
      i_qwrb_master.wr_byte({`QWRB_DEV_TYPE, strap}, a);
      i_qwrb_master.wr_byte(ins, a);
      i_qwrb_master.rd_byte(1'b1, d);
      i_qwrb_master.rd_byte(1'b0, d2);
      i_qwrb_master.stop();
      repeat (4) @(posedge clk_sys);
      chk("read", e, d);
      chk("read again", e, d2);
   endtask

   task automatic do_reset();
      @(negedge clk_sys);
      rst_b = 1'b0;
      repeat (20) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (5) @(negedge clk_sys);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial begin
      logic [2:0] ak;
      logic [7:0] v;
      int s;
      rst_b = 1'b0;
      wp_b = 1'b1;
      strap = 4'h0;
      v = 8'($urandom(13534));
      @(negedge clk_sys);
      strap = 4'($urandom);
      do_reset();
      // All sixteen saved settings written and read back
      for (int i = 0; i < 16; i++) begin
         v = 8'($urandom);
         send(strap, {`QWRB_OP_WR_SAVED, 4'(i)}, v, ak);
         chk("wr saved ack", 3'b111, ak);
         sav[i] = v;
         rd({`QWRB_OP_RD_SAVED, 4'(i)}, sav[i]);
      end
      // Second reset recalls the first saved setting of each pot
      do_reset();
      for (int p = 0; p < 4; p++) wip[p] = sav[p * 4];
      cmp_all();
      // Wiper writes at both ends of the range, slow master too
      i_qwrb_master.stall = 200.0;
      for (int p = 0; p < 4; p++) begin
         v = (p == 0) ? `QWRB_WIPER_MIN : (p == 3) ? `QWRB_WIPER_MAX : 8'($urandom);
         send(strap, {`QWRB_OP_WR_WIPER, 2'(p), 2'b00}, v, ak);
         chk("wr wiper ack", 3'b111, ak);
         wip[p] = v;
         rd({`QWRB_OP_RD_WIPER, 2'(p), 2'b00}, wip[p]);
      end
      i_qwrb_master.stall = 0.0;
      cmp_all();
      // Saved to wiper, then wiper to another saved slot
      for (int p = 0; p < 4; p++) begin
         s = $urandom_range(3);
         move({`QWRB_OP_LD_WIPER, 2'(p), 2'(s)}, 1'b1);
         wip[p] = sav[p * 4 + s];
         cmp_all();
         s = (s + 1) % 4;
         move({`QWRB_OP_ST_SAVED, 2'(p), 2'(s)}, 1'b1);
         sav[p * 4 + s] = wip[p];
         rd({`QWRB_OP_RD_SAVED, 2'(p), 2'(s)}, sav[p * 4 + s]);
      end
      // Steps saturate at both ends
      for (int k = 0; k < 2; k++) begin
         send(strap, {`QWRB_OP_WR_WIPER, 4'h0}, k ? 8'h01 : 8'hFE, ak);
         wip[0] = k ? 1 : 254;
         for (int j = 0; j < 2; j++) begin
            send(strap, {`QWRB_OP_STEP, 4'h0}, k ? 8'h00 : 8'h01, ak);
            wip[0] = k ? ((wip[0] == 0) ? 0 : wip[0] - 1) : ((wip[0] == 255) ? 255 : wip[0] + 1);
            chk("step ack", 3'b111, ak);
            cmp_all();
         end
      end
      // Wrong strap bits are ignored
      for (int k = 0; k < 4; k++) begin
         send(strap ^ (4'h1 << k), {`QWRB_OP_WR_WIPER, 4'h4}, 8'($urandom), ak);
         chk("foreign ack", 3'b000, ak);
         cmp_all();
      end
      // Protection: nonvolatile writes refused, wiper writes taken
      @(negedge clk_sys);
      wp_b = 1'b0;
      repeat (4) @(negedge clk_sys);
      send(strap, {`QWRB_OP_WR_SAVED, 4'h6}, ~sav[6][7:0], ak);
      chk("protected ack", 3'b110, ak);
      rd({`QWRB_OP_RD_SAVED, 4'h6}, sav[6]);
      move({`QWRB_OP_ST_SAVED, 4'h7}, 1'b0);
      rd({`QWRB_OP_RD_SAVED, 4'h7}, sav[7]);
      v = 8'($urandom);
      send(strap, {`QWRB_OP_WR_WIPER, 4'h8}, v, ak);
      chk("wiper under wp ack", 3'b111, ak);
      wip[2] = v;
      cmp_all();
      @(negedge clk_sys);
      wp_b = 1'b1;
      // Undefined opcode refused
      send(strap, 8'h04, 8'h55, ak);
      chk("bad op ack", 3'b100, ak);
      cmp_all();
      end_sim();
   end
endmodule
